/* hdl/wdt_map.svh */
// Register offsets, field positions, reset values and timing counts for the watchdog block
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ==========================================================================
// Register addresses (byte addresses on the peripheral bus)
`define WDT_ADDR_STAB_WAIT   32'hfffff380
`define WDT_ADDR_PERIOD      32'hfffff382
`define WDT_ADDR_MODE        32'hfffff384

// ==========================================================================
// Reset values
`define WDT_RST_STAB_WAIT    8'h04
`define WDT_RST_PERIOD       8'h00
`define WDT_RST_MODE         8'h00

// ==========================================================================
// Field positions
`define WDT_CODE_MSB         2
`define WDT_RUN_BIT          7
`define WDT_MODE_BIT         4

// ==========================================================================
// Counter geometry: low prescaler stage and full width
`define WDT_PRESC_BITS       10
`define WDT_CNT_BITS         23

// ==========================================================================
// Stabilization wait terminal counts (selected cycles minus one)
`define WDT_WAIT_2P14        20'h03fff
`define WDT_WAIT_2P16        20'h0ffff
`define WDT_WAIT_2P17        20'h1ffff
`define WDT_WAIT_2P18        20'h3ffff
`define WDT_WAIT_2P19        20'h7ffff

`endif

/* hdl/wdt_pkg.sv */
// Types shared by the watchdog block
`default_nettype none
package wdt_pkg;

	// Stabilization sequencer states
	typedef enum logic [1:0] {
		WDT_ST_IDLE,
		WDT_ST_WAIT,
		WDT_ST_DONE
	} wdt_stab_e;

	// Three-bit period or wait code
	typedef logic [2:0] wdt_code_t;

endpackage : wdt_pkg
`default_nettype wire

/* hdl/wdt_stab_wait.sv */
// Oscillation stabilization wait counter after reset or stop release
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_stab_wait
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic      mclk,
	input  wire logic      reset,
	// Control
	input  wire logic      stop_release,
	input  wire wdt_code_t code,
	// Status
	output logic           osc_stable
);

	logic [19:0] cnt_q, cnt_d;
	logic [19:0] limit;
	wdt_stab_e   st_q, st_d;
	logic        stable_q, stable_d;

	// ==================================================================
	// Decode of the wait code into a cycle count
	always_comb begin
		case (code)
			3'h0:    limit = `WDT_WAIT_2P14; // 2^14 cycles
			3'h1:    limit = `WDT_WAIT_2P16; // 2^16 cycles
			3'h2:    limit = `WDT_WAIT_2P17; // 2^17 cycles
			3'h3:    limit = `WDT_WAIT_2P18; // 2^18 cycles
			// Forbidden codes fall back to the longest wait as a safe choice
			default: limit = `WDT_WAIT_2P19; // 2^19 cycles
		endcase
	end

	// ==================================================================
	// Sequencer: wait starts at reset release or on stop release
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		stable_d = stable_q;
		case (st_q)
			WDT_ST_IDLE: begin
				st_d     = WDT_ST_WAIT;
				cnt_d    = 20'h00000;
				stable_d = 1'b0;
			end
			WDT_ST_WAIT: begin
				if (cnt_q >= limit) begin
					st_d     = WDT_ST_DONE;
					stable_d = 1'b1;
				end else begin
					cnt_d = cnt_q + 20'h00001;
				end
			end
			WDT_ST_DONE: begin
				if (stop_release) begin
					st_d     = WDT_ST_IDLE;
					stable_d = 1'b0;
				end
			end
			default: st_d = WDT_ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_q     <= WDT_ST_IDLE;
			cnt_q    <= 20'h00000;
			stable_q <= 1'b0;
		end else begin
			st_q     <= st_d;
			cnt_q    <= cnt_d;
			stable_q <= stable_d;
		end
	end

	assign osc_stable = stable_q;

	// Stable only after the full counted wait
	AST_STAB_AFTER_WAIT: assert property (@(posedge mclk) disable iff (reset)
		$rose(stable_q) |-> $past(st_q) == WDT_ST_WAIT && $past(cnt_q) >= $past(limit))
		else $error("stable raised before the wait elapsed");

endmodule : wdt_stab_wait
`default_nettype wire

/* hdl/wdt_ctrl.sv */
// Watchdog / interval timer with its three control registers
// What this block does
// - Wait code 0..4 selects 2^14,16,17,18,19 cycles; other codes forbidden.
// - Wait register resets to 04h.
// - Period code 0..7 selects 2^14..2^20 and 2^22 cycles.
// - Period register resets to 00h.
// - Mode register resets to 00h: stopped, interval mode.
// - Writing run bit 1 clears counter and starts counting; 0 means stopped.
// - Once running, writing run 0 is ignored; only reset stops it.
// - Mode bit 0: overflow raises maskable interval request.
// - Mode bit 1: overflow raises non-maskable watchdog request.
// - Mode bit once set stays set until reset.
// - Restart leaves low prescaler running; first overflow may come 2^10 early.
// - Stabilization wait applies after reset or stop release.
// - Rewriting run bit in watchdog mode restarts count, avoiding overflow.
// - Counter holds on subclock and stops in stop and idle modes.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"

module wdt_ctrl
	import wdt_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// Memory-mapped register port
	input  wire logic [31:0] addr,
	input  wire logic        wr_en,
	input  wire logic        bit_wr,
	input  wire logic [2:0]  bit_sel,
	input  wire logic [7:0]  wdata,
	output logic      [7:0]  rdata,
	// Clock and standby status
	input  wire logic        cpu_on_subclk,
	input  wire logic        standby_stop,
	input  wire logic        standby_idle,
	input  wire logic        stop_release,
	// Requests and status
	output logic             runaway_nmi_request,
	output logic             interval_irq_request,
	output logic             osc_stable
);

	localparam logic [`WDT_CNT_BITS-1:0] CNT_ONE  = 23'h000001;
	// Mode reset byte, so each sticky bit takes its own field of it
	localparam logic [7:0]               MODE_RST = `WDT_RST_MODE;

	logic [7:0] stab_q, stab_d;
	logic [7:0] period_q, period_d;
	logic       run_q, run_d;
	logic       mode_q, mode_d;
	logic [`WDT_CNT_BITS-1:0] cnt_q, cnt_d;
	logic       nmi_q, nmi_d;
	logic       irq_q, irq_d;
	logic [7:0] rdata_q, rdata_d;
	logic [7:0] wbyte;
	logic [7:0] mode_rd;
	logic       sel_stab, sel_period, sel_mode;
	logic       restart;
	logic       hold;
	logic       ovf;
	logic [2:0] upper;
	logic [`WDT_CNT_BITS-1:0] cnt_inc;

	// ==================================================================
	// Address decode and write data shaping
	assign sel_stab   = (addr == `WDT_ADDR_STAB_WAIT);
	assign sel_period = (addr == `WDT_ADDR_PERIOD);
	assign sel_mode   = (addr == `WDT_ADDR_MODE);
	assign mode_rd    = {run_q, 2'b00, mode_q, 4'b0000};

	// Bit writes merge one bit into current contents; only mode honours them
	always_comb begin
		wbyte = mode_rd;
		if (bit_wr)
			wbyte[bit_sel] = wdata[0];
		else
			wbyte = wdata;
	end

	// ==================================================================
	// Register file next state
	always_comb begin
		stab_d   = stab_q;
		period_d = period_q;
		run_d    = run_q;
		mode_d   = mode_q;
		restart  = 1'b0;
		if (wr_en && !bit_wr && sel_stab)
			stab_d = {5'b00000, wdata[`WDT_CODE_MSB:0]};
		if (wr_en && !bit_wr && sel_period)
			period_d = {5'b00000, wdata[`WDT_CODE_MSB:0]};
		if (wr_en && sel_mode) begin
			// Sticky bits: a 0 never clears them
			run_d  = run_q | wbyte[`WDT_RUN_BIT];
			mode_d = mode_q | wbyte[`WDT_MODE_BIT];
			// Any write with run at 1 clears the counter above the low prescaler stage
			restart = wbyte[`WDT_RUN_BIT];
		end
	end

	// ==================================================================
	// Period decode: the bit position whose carry marks overflow
	always_comb begin
		case (period_q[2:0])
			3'h7:    upper = 3'h7; // 2^22
			default: upper = period_q[2:0]; // 2^(14+code)
		endcase
	end

	// ==================================================================
	// Counter: low 10 bits keep their count on restart, upper stage cleared on restart
	assign hold    = cpu_on_subclk || standby_stop || standby_idle;
	assign cnt_inc = cnt_q + CNT_ONE;
	// Overflow when bits up to the selected width are all ones
	assign ovf = run_q && !hold && !restart &&
		(&cnt_q[13:0]) &&
		((upper == 3'h7) ? (&cnt_q[21:14]) :
		 (upper == 3'h0) ? 1'b1 :
		 (&(cnt_q[20:14] | ~(7'h7f >> (3'd7 - upper)))));

	always_comb begin
		cnt_d = cnt_q;
		nmi_d = 1'b0;
		irq_d = 1'b0;
		if (restart) begin
			// Low prescaler keeps running, so first overflow may be early
			cnt_d = {{(`WDT_CNT_BITS-`WDT_PRESC_BITS){1'b0}},
				cnt_q[`WDT_PRESC_BITS-1:0]};
		end else if (run_q && !hold) begin
			cnt_d = ovf ? '0 : cnt_inc;
			nmi_d = ovf && mode_q;
			irq_d = ovf && !mode_q;
		end
	end

	// Read mux: unmapped addresses read zero
	always_comb begin
		rdata_d = 8'h00;
		if (sel_stab)
			rdata_d = stab_q;
		else if (sel_period)
			rdata_d = period_q;
		else if (sel_mode)
			rdata_d = mode_rd;
	end

	// ==================================================================
	// State registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			stab_q   <= `WDT_RST_STAB_WAIT;
			period_q <= `WDT_RST_PERIOD;
			run_q    <= MODE_RST[`WDT_RUN_BIT];
			mode_q   <= MODE_RST[`WDT_MODE_BIT];
			cnt_q    <= '0;
			nmi_q    <= 1'b0;
			irq_q    <= 1'b0;
			rdata_q  <= 8'h00;
		end else begin
			stab_q   <= stab_d;
			period_q <= period_d;
			run_q    <= run_d;
			mode_q   <= mode_d;
			cnt_q    <= cnt_d;
			nmi_q    <= nmi_d;
			irq_q    <= irq_d;
			rdata_q  <= rdata_d;
		end
	end

	assign rdata                = rdata_q;
	assign runaway_nmi_request  = nmi_q;
	assign interval_irq_request = irq_q;

	// ==================================================================
	// Stabilization wait sequencer
	wdt_stab_wait u_stab (
		.mclk         (mclk),
		.reset        (reset),
		.stop_release (stop_release),
		.code         (stab_q[2:0]),
		.osc_stable   (osc_stable)
	);

	// ==================================================================
	// Checks
	sequence s_run_set;
		run_q;
	endsequence

	AST_STAB_RESET: assert property (@(posedge mclk)
		$past(reset) |-> stab_q == 8'h04)
		else $error("wait register not 04h after reset");
	AST_PERIOD_RESET: assert property (@(posedge mclk)
		$past(reset) |-> period_q == 8'h00)
		else $error("period register not 00h after reset");
	AST_MODE_RESET: assert property (@(posedge mclk)
		$past(reset) |-> !run_q && !mode_q)
		else $error("mode register not cleared after reset");
	AST_RUN_STICKY: assert property (@(posedge mclk) disable iff (reset)
		s_run_set |=> run_q)
		else $error("run bit cleared without reset");
	AST_MODE_STICKY: assert property (@(posedge mclk) disable iff (reset)
		mode_q |=> mode_q)
		else $error("mode bit cleared without reset");
	AST_STOPPED_QUIET: assert property (@(posedge mclk) disable iff (reset)
		!run_q |=> !nmi_q && !irq_q && $stable(cnt_q))
		else $error("counting while run bit clear");
	AST_RESTART_CLEARS: assert property (@(posedge mclk) disable iff (reset)
		restart |=> cnt_q[`WDT_CNT_BITS-1:`WDT_PRESC_BITS] == '0 && !nmi_q)
		else $error("restart did not clear the upper count");
	AST_NMI_MODE: assert property (@(posedge mclk) disable iff (reset)
		nmi_q |-> mode_q && !irq_q)
		else $error("nmi raised outside watchdog mode");
	AST_IRQ_MODE: assert property (@(posedge mclk) disable iff (reset)
		irq_q |-> !$past(mode_q) && $past(ovf))
		else $error("interval request without overflow");
	AST_HOLD: assert property (@(posedge mclk) disable iff (reset)
		hold && !restart |=> $stable(cnt_q))
		else $error("counter moved while held");
	AST_ZERO_BITS: assert property (@(posedge mclk) disable iff (reset)
		stab_q[7:3] == 5'h00 && period_q[7:3] == 5'h00)
		else $error("fixed-zero bits set");
	AST_WAIT_CODE: assert property (@(posedge mclk) disable iff (reset)
		$rose(osc_stable) |-> u_stab.cnt_q >= `WDT_WAIT_2P14 && u_stab.cnt_q <= `WDT_WAIT_2P19)
		else $error("wait outside the selectable range");
	AST_PRESC_EARLY: assert property (@(posedge mclk) disable iff (reset)
		restart |=> cnt_q[`WDT_PRESC_BITS-1:0] == $past(cnt_q[`WDT_PRESC_BITS-1:0]))
		else $error("prescaler disturbed by restart");
	AST_BYTE_ONLY: assert property (@(posedge mclk) disable iff (reset)
		wr_en && bit_wr && !sel_mode |=> $stable(stab_q) && $stable(period_q))
		else $error("bit write changed a byte-only register");

endmodule : wdt_ctrl
`default_nettype wire

/* dv/wdt_ctrl_tb.sv */
// Self-checking testbench for the watchdog and interval timer control block
`timescale 1ns/1ps
`default_nettype none
`include "wdt_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %h got %h", nm, e, g); end end

module watchdog_interval_timer_ctrl_tb;
	import wdt_pkg::*;
	// ==================================================================
	// Stimulus and observed signals
	logic        mclk, reset, wr_en, bit_wr, cpu_on_subclk, standby_stop;
	logic        standby_idle, stop_release, nmi, irq, osc_stable;
	logic [31:0] addr;
	logic [2:0]  bit_sel;
	logic [7:0]  wdata, rdata;
	int          failures, samples_checked;
	localparam int P = 16384;  // Period code 0 keeps every overflow short
	localparam int LO = P - 1024 - 8;  // Uncleared low stage may fire early

	wdt_ctrl u_dut (.mclk(mclk), .reset(reset), .addr(addr), .wr_en(wr_en), .bit_wr(bit_wr),
		.bit_sel(bit_sel), .wdata(wdata), .rdata(rdata), .cpu_on_subclk(cpu_on_subclk),
		.standby_stop(standby_stop), .standby_idle(standby_idle),
		.stop_release(stop_release), .runaway_nmi_request(nmi),
		.interval_irq_request(irq), .osc_stable(osc_stable));

	// ==================================================================
	// Bus cycles; a write is taken at the edge where the strobe is high
	task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic b, input int s);
		@(posedge mclk);
		addr <= a; wdata <= d; bit_wr <= b; bit_sel <= s[2:0]; wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask : wr

	// Extra edge leaves room for the registered read path
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		@(posedge mclk);
		addr <= a;
		repeat (2) @(posedge mclk);
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd

	task automatic quiet(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge mclk);
			#1;
			seen = seen | nmi | irq;
		end
		`CHK("no_request", 1'b0, seen)
	endtask : quiet

	// Waits for one request and checks that the other stays low
	task automatic wait_pulse(input logic want_nmi);
		int n;
		logic hit, other;
		n = 0; hit = 1'b0; other = 1'b0;
		while (hit !== 1'b1 && n <= P + 8) begin
			@(posedge mclk);
			#1;
			n++;
			hit = want_nmi ? nmi : irq;
			other = other | (want_nmi ? irq : nmi);
		end
		// A request stands for one cycle only
		@(posedge mclk);
		#1;
		`CHK("pulse_len", 1'b0, want_nmi ? nmi : irq)
		`CHK("pulse_window", 1'b1, hit === 1'b1 && n >= LO)
		`CHK("other_request", 1'b0, other)
	endtask : wait_pulse

	// ==================================================================
	// Scenarios
	task automatic t_reset_values();
		`CHK("osc_stable", 1'b0, osc_stable)
		rd(`WDT_ADDR_STAB_WAIT, 8'h04);
		rd(`WDT_ADDR_PERIOD, 8'h00);
		rd(`WDT_ADDR_MODE, 8'h00);
		rd(32'hfffff386, 8'h00);
	endtask : t_reset_values

	// Fixed-zero bits and refused bit writes on the byte-only registers
	task automatic t_fields();
		wr(`WDT_ADDR_STAB_WAIT, 8'hff, 1'b0, 0);
		rd(`WDT_ADDR_STAB_WAIT, 8'h07);
		wr(`WDT_ADDR_STAB_WAIT, 8'h00, 1'b1, 0);
		rd(`WDT_ADDR_STAB_WAIT, 8'h07);
		wr(`WDT_ADDR_PERIOD, 8'hff, 1'b0, 0);
		rd(`WDT_ADDR_PERIOD, 8'h07);
		wr(`WDT_ADDR_PERIOD, 8'h00, 1'b1, 1);
		rd(`WDT_ADDR_PERIOD, 8'h07);
		wr(`WDT_ADDR_PERIOD, 8'h00, 1'b0, 0);
		wr(`WDT_ADDR_MODE, 8'h2f, 1'b0, 0);
		rd(`WDT_ADDR_MODE, 8'h00);
		quiet(40);
	endtask : t_fields

	task automatic t_interval();
		wr(`WDT_ADDR_MODE, 8'h80, 1'b0, 0);
		wait_pulse(1'b0);
		wr(`WDT_ADDR_MODE, 8'h00, 1'b0, 0);
		rd(`WDT_ADDR_MODE, 8'h80);
	endtask : t_interval

	// Each hold input in turn freezes the count
	task automatic t_hold();
		wr(`WDT_ADDR_MODE, 8'h80, 1'b0, 0);
		for (int i = 0; i < 3; i++) begin
			@(posedge mclk);
			{cpu_on_subclk, standby_stop, standby_idle} <= 3'b001 << i;
			quiet(2700);
		end
		@(posedge mclk);
		{cpu_on_subclk, standby_stop, standby_idle} <= 3'b000;
		wait_pulse(1'b0);
	endtask : t_hold

	task automatic t_watchdog();
		wr(`WDT_ADDR_MODE, 8'h01, 1'b1, 4);
		rd(`WDT_ADDR_MODE, 8'h90);
		wr(`WDT_ADDR_MODE, 8'h00, 1'b1, 4);
		wr(`WDT_ADDR_MODE, 8'h00, 1'b1, 7);
		rd(`WDT_ADDR_MODE, 8'h90);
		wr(`WDT_ADDR_MODE, 8'h90, 1'b0, 0);
		quiet(12000);
		wr(`WDT_ADDR_MODE, 8'h80, 1'b0, 0);
		rd(`WDT_ADDR_MODE, 8'h90);
		wait_pulse(1'b1);
	endtask : t_watchdog

	task automatic t_osc();
		int n;
		n = 0;
		wr(`WDT_ADDR_STAB_WAIT, 8'h00, 1'b0, 0);
		@(posedge mclk);
		stop_release <= 1'b1;
		@(posedge mclk);
		stop_release <= 1'b0;
		#1;
		`CHK("osc_stable", 1'b0, osc_stable)
		while (osc_stable !== 1'b1 && n <= P + 8) begin
			@(posedge mclk);
			#1;
			n++;
		end
		`CHK("stab_window", 1'b1, osc_stable === 1'b1 && n >= P - 4)
	endtask : t_osc

	// ==================================================================
	// Verdict, clock, main sequence and watchdog
	task automatic end_of_test();
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end

	initial begin
		{reset, wr_en, bit_wr, cpu_on_subclk, standby_stop, standby_idle} = 6'h20;
		{stop_release, addr, bit_sel, wdata} = '0;
		failures = 0;
		samples_checked = 0;
		repeat (16) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		t_reset_values();
		t_fields();
		t_interval();
		t_hold();
		t_watchdog();
		t_osc();
		end_of_test();
	end

	// Scenarios need about 85000 cycles; stop a hang soon after that
	initial begin
		repeat (99000) @(posedge mclk);
		failures++;
		end_of_test();
	end
endmodule : watchdog_interval_timer_ctrl_tb
`default_nettype wire
